// File: include/relay_pkg.sv
// constants shared by the matrix card loader and its clock divider
package relay_pkg;
   // system clock and peripheral clock rates
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned PERIPH_HZ = 1_790_000;
   // half period of the peripheral clock, rounded to the nearest cycle
   localparam int unsigned PERIPH_HALF_CYC = (CLK_HZ + PERIPH_HZ) / (2 * PERIPH_HZ);
   // processor reset hold, least time 110 ms in whole cycles, CLK_HZ / 1000 truncated, no rounding up
   localparam int unsigned RESET_HOLD_MS = 110;
   localparam int unsigned RESET_HOLD_CYC = (RESET_HOLD_MS * (CLK_HZ / 1000) + 0) ;
   localparam int unsigned RESET_CNT_W = 23;
   // bits per card transfer
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] BIT_CNT_RST = 4'h0;
   // output levels after reset
   localparam logic PROC_RESET_RST = 1'b0;
   localparam logic CLEAR_RST = 1'b0;
   localparam logic ADVANCE_N_RST = 1'b1;
   localparam logic SELECT_N_RST = 1'b1;
   localparam logic SER_CLK_RST = 1'b1;
   localparam logic [7:0] BYTE_RST = 8'h00;
   // sequencer states
   typedef enum logic [2:0] {
      ST_HOLD   = 3'h0,
      ST_CLEAR  = 3'h1,
      ST_ADV    = 3'h2,
      ST_IDBITS = 3'h3,
      ST_IDLE   = 3'h4,
      ST_SELECT = 3'h5,
      ST_BITS   = 3'h6
   } seq_state_t;
endpackage

// File: include/tick_if.sv
// peripheral clock level and its edge enables, divider to sequencer
`timescale 1ns/100ps
interface tick_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport snk (input level, input rise, input fall);
endinterface

// File: hw/tick_divider.sv
// square-wave divider producing one-cycle edge enables
`timescale 1ns/100ps
module tick_divider #(
   parameter int unsigned HALF_CYC = relay_pkg::PERIPH_HALF_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // ticks out
   tick_if.src tick
);
   localparam int CNT_W = $clog2(HALF_CYC + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF_CYC - 1);

   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic level_ff, nxt_level;
   logic rise_ff, nxt_rise;
   logic fall_ff, nxt_fall;

   if (HALF_CYC < 2) begin : g_chk
      $error("tick_divider: HALF_CYC must be at least 2");
   end

   // free-running count, toggle at each half period
   always_comb begin
      nxt_cnt = cnt_ff + CNT_W'(1);
      nxt_level = level_ff;
      nxt_rise = 1'b0;
      nxt_fall = 1'b0;
      if (cnt_ff == LAST) begin
         nxt_cnt = '0;
         nxt_level = ~level_ff;
         nxt_rise = ~level_ff;
         nxt_fall = level_ff;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_ff <= '0;
         level_ff <= 1'b0;
         rise_ff <= 1'b0;
         fall_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         level_ff <= nxt_level;
         rise_ff <= nxt_rise;
         fall_ff <= nxt_fall;
      end
   end

   assign tick.level = level_ff;
   assign tick.rise = rise_ff;
   assign tick.fall = fall_ff;
endmodule

// File: hw/matrix_relay_loader.sv
// matrix card loader: power-up id read and relay byte bursts
`timescale 1ns/100ps
module matrix_relay_loader #(
   parameter int unsigned RESET_HOLD_CYC = relay_pkg::RESET_HOLD_CYC,
   parameter int unsigned ID_BYTES = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // processor side
   output logic processor_reset_o,
   output logic periph_clk_o,
   // relay update request
   input wire logic relay_req_i,
   input wire logic [7:0] relay_byte_i,
   output logic relay_busy_o,
   output logic relay_done_o,
   // identification results
   output logic [7:0] id_byte_o,
   output logic [7:0] id_index_o,
   output logic id_valid_o,
   output logic id_done_o,
   // matrix card pins
   output logic card_addr_clear_o,
   output logic card_addr_advance_n_o,
   input wire logic card_id_serial_in_i,
   output logic relay_load_select_n_o,
   output logic relay_ser_clk_n_o,
   output logic relay_serial_out_o
);
   localparam logic [7:0] LAST_ID = 8'(ID_BYTES - 1);
   localparam logic [relay_pkg::RESET_CNT_W-1:0] HOLD_LAST =
      relay_pkg::RESET_CNT_W'(RESET_HOLD_CYC - 1);

   if (ID_BYTES < 1 || ID_BYTES > 256) begin : g_chk_id
      $error("matrix_relay_loader: ID_BYTES must be 1..256");
   end
   if (RESET_HOLD_CYC < 1 || RESET_HOLD_CYC >= (1 << relay_pkg::RESET_CNT_W)) begin : g_chk_rst
      $error("matrix_relay_loader: RESET_HOLD_CYC out of range");
   end

   tick_if tick ();

   tick_divider #(
      .HALF_CYC(relay_pkg::PERIPH_HALF_CYC)
   ) u_div (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .tick(tick.src)
   );

   // id input synchroniser; the filtered level moves only when stages 2 and 3 agree
   logic id_s1_ff, id_s2_ff, id_s3_ff, id_filt_ff, nxt_id_filt;

   always_comb begin
      nxt_id_filt = id_filt_ff;
      if (id_s2_ff == id_s3_ff) begin
         nxt_id_filt = id_s3_ff;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         id_s1_ff <= 1'b0;
         id_s2_ff <= 1'b0;
         id_s3_ff <= 1'b0;
         id_filt_ff <= 1'b0;
      end else begin
         id_s1_ff <= card_id_serial_in_i;
         id_s2_ff <= id_s1_ff;
         id_s3_ff <= id_s2_ff;
         id_filt_ff <= nxt_id_filt;
      end
   end

   // sequencer state
   relay_pkg::seq_state_t state_ff, nxt_state;
   logic [relay_pkg::RESET_CNT_W-1:0] hold_cnt_ff, nxt_hold_cnt;
   logic [3:0] bit_cnt_ff, nxt_bit_cnt;
   logic [7:0] byte_idx_ff, nxt_byte_idx;
   logic [7:0] shift_ff, nxt_shift;
   logic proc_rst_ff, nxt_proc_rst;
   logic periph_ff;
   logic clear_ff, nxt_clear;
   logic adv_n_ff, nxt_adv_n;
   logic sel_n_ff, nxt_sel_n;
   logic ser_clk_n_ff, nxt_ser_clk_n;
   logic ser_data_ff, nxt_ser_data;
   logic busy_ff, nxt_busy;
   logic done_ff, nxt_done;
   logic [7:0] id_byte_ff, nxt_id_byte;
   logic [7:0] id_index_ff, nxt_id_index;
   logic id_valid_ff, nxt_id_valid;
   logic id_done_ff, nxt_id_done;

   // next-state logic; all card pin changes land on peripheral clock edges
   always_comb begin
      nxt_state = state_ff;
      nxt_hold_cnt = hold_cnt_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_byte_idx = byte_idx_ff;
      nxt_shift = shift_ff;
      nxt_proc_rst = proc_rst_ff;
      nxt_clear = clear_ff;
      nxt_adv_n = adv_n_ff;
      nxt_sel_n = sel_n_ff;
      nxt_ser_clk_n = ser_clk_n_ff;
      nxt_ser_data = ser_data_ff;
      nxt_busy = busy_ff;
      nxt_done = 1'b0;
      nxt_id_byte = id_byte_ff;
      nxt_id_index = id_index_ff;
      nxt_id_valid = 1'b0;
      nxt_id_done = id_done_ff;
      case (state_ff)
         relay_pkg::ST_HOLD: begin
            // keep the processor in reset, then release before any card traffic
            if (hold_cnt_ff == HOLD_LAST) begin
               nxt_proc_rst = 1'b1;
               if (proc_rst_ff && tick.rise) begin
                  nxt_state = relay_pkg::ST_CLEAR;
                  nxt_clear = 1'b1;
               end
            end else begin
               nxt_hold_cnt = hold_cnt_ff + relay_pkg::RESET_CNT_W'(1);
            end
         end
         relay_pkg::ST_CLEAR: begin
            // clear pulse lasts one peripheral period
            if (tick.rise) begin
               nxt_clear = 1'b0;
               nxt_adv_n = 1'b0;
               nxt_state = relay_pkg::ST_ADV;
            end
         end
         relay_pkg::ST_ADV: begin
            if (tick.rise) begin
               nxt_adv_n = 1'b1;
               nxt_bit_cnt = relay_pkg::BIT_CNT_RST;
               nxt_state = relay_pkg::ST_IDBITS;
            end
         end
         relay_pkg::ST_IDBITS: begin
            // sample on the falling edge, where the card also shifts; the synchroniser delay still holds the old bit
            if (tick.fall && bit_cnt_ff != relay_pkg::BITS_PER_BYTE) begin
               nxt_shift = {shift_ff[6:0], id_filt_ff};
               nxt_bit_cnt = bit_cnt_ff + 4'h1;
            end
            if (tick.rise && bit_cnt_ff == relay_pkg::BITS_PER_BYTE) begin
               nxt_id_byte = shift_ff;
               nxt_id_index = byte_idx_ff;
               nxt_id_valid = 1'b1;
               if (byte_idx_ff == LAST_ID) begin
                  nxt_id_done = 1'b1;
                  nxt_state = relay_pkg::ST_IDLE;
               end else begin
                  nxt_byte_idx = byte_idx_ff + 8'h01;
                  nxt_adv_n = 1'b0;
                  nxt_state = relay_pkg::ST_ADV;
               end
            end
         end
         relay_pkg::ST_IDLE: begin
            // a request is latched at once; the burst waits for the next rising edge
            if (!busy_ff && relay_req_i) begin
               nxt_busy = 1'b1;
               nxt_shift = relay_byte_i;
            end
            if (busy_ff && tick.rise) begin
               nxt_sel_n = 1'b0;
               nxt_state = relay_pkg::ST_SELECT;
            end
         end
         relay_pkg::ST_SELECT: begin
            if (tick.rise) begin
               nxt_sel_n = 1'b1;
               nxt_bit_cnt = relay_pkg::BIT_CNT_RST;
               nxt_state = relay_pkg::ST_BITS;
            end
         end
         relay_pkg::ST_BITS: begin
            // data moves with the falling clock so it is settled at the rising edge
            if (tick.fall && bit_cnt_ff != relay_pkg::BITS_PER_BYTE) begin
               nxt_ser_clk_n = 1'b0;
               nxt_ser_data = shift_ff[7];
               nxt_shift = {shift_ff[6:0], 1'b0};
               nxt_bit_cnt = bit_cnt_ff + 4'h1;
            end
            if (tick.rise) begin
               nxt_ser_clk_n = 1'b1;
               if (bit_cnt_ff == relay_pkg::BITS_PER_BYTE) begin
                  nxt_busy = 1'b0;
                  nxt_done = 1'b1;
                  nxt_state = relay_pkg::ST_IDLE;
               end
            end
         end
         default: begin
            nxt_state = relay_pkg::ST_HOLD;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_ff <= relay_pkg::ST_HOLD;
         hold_cnt_ff <= '0;
         bit_cnt_ff <= relay_pkg::BIT_CNT_RST;
         byte_idx_ff <= 8'h00;
         shift_ff <= relay_pkg::BYTE_RST;
         proc_rst_ff <= relay_pkg::PROC_RESET_RST;
         periph_ff <= 1'b0;
         clear_ff <= relay_pkg::CLEAR_RST;
         adv_n_ff <= relay_pkg::ADVANCE_N_RST;
         sel_n_ff <= relay_pkg::SELECT_N_RST;
         ser_clk_n_ff <= relay_pkg::SER_CLK_RST;
         ser_data_ff <= 1'b0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         id_byte_ff <= relay_pkg::BYTE_RST;
         id_index_ff <= 8'h00;
         id_valid_ff <= 1'b0;
         id_done_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         hold_cnt_ff <= nxt_hold_cnt;
         bit_cnt_ff <= nxt_bit_cnt;
         byte_idx_ff <= nxt_byte_idx;
         shift_ff <= nxt_shift;
         proc_rst_ff <= nxt_proc_rst;
         periph_ff <= tick.level;
         clear_ff <= nxt_clear;
         adv_n_ff <= nxt_adv_n;
         sel_n_ff <= nxt_sel_n;
         ser_clk_n_ff <= nxt_ser_clk_n;
         ser_data_ff <= nxt_ser_data;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
         id_byte_ff <= nxt_id_byte;
         id_index_ff <= nxt_id_index;
         id_valid_ff <= nxt_id_valid;
         id_done_ff <= nxt_id_done;
      end
   end

   // every output straight from a flip-flop
   assign processor_reset_o = proc_rst_ff;
   assign periph_clk_o = periph_ff;
   assign relay_busy_o = busy_ff;
   assign relay_done_o = done_ff;
   assign id_byte_o = id_byte_ff;
   assign id_index_o = id_index_ff;
   assign id_valid_o = id_valid_ff;
   assign id_done_o = id_done_ff;
   assign card_addr_clear_o = clear_ff;
   assign card_addr_advance_n_o = adv_n_ff;
   assign relay_load_select_n_o = sel_n_ff;
   assign relay_ser_clk_n_o = ser_clk_n_ff;
   assign relay_serial_out_o = ser_data_ff;
endmodule

// File: bench/relay_monitor.sv
// assertions on the matrix card loader pins
`timescale 1ns/100ps
module relay_monitor (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // watched outputs
   input logic processor_reset_o,
   input logic periph_clk_o,
   input logic relay_busy_o,
   input logic relay_done_o,
   input logic id_done_o,
   input logic card_addr_clear_o,
   input logic card_addr_advance_n_o,
   input logic relay_load_select_n_o,
   input logic relay_ser_clk_n_o,
   input logic relay_serial_out_o
);
   logic [4:0] run_ff, nxt_run;
   logic [3:0] ncl_ff, nxt_ncl;
   logic prev_ff, seen_ff, clr_ff, sck_ff, nxt_seen, nxt_clr;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // level run length, clear seen, serial clock falls since select
   always_comb begin
      nxt_run = (periph_clk_o != prev_ff) ? 5'h00 : run_ff + 5'h01;
      nxt_seen = seen_ff | (periph_clk_o != prev_ff);
      nxt_clr = clr_ff | card_addr_clear_o;
      nxt_ncl = ncl_ff;
      if (!relay_load_select_n_o) nxt_ncl = 4'h0;
      else if (sck_ff && !relay_ser_clk_n_o) nxt_ncl = ncl_ff + 4'h1;
   end
   // helper registers only, no checking here
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) {run_ff, prev_ff, seen_ff, clr_ff, sck_ff, ncl_ff} <= '0;
      else {run_ff, prev_ff, seen_ff, clr_ff, sck_ff, ncl_ff} <=
         {nxt_run, periph_clk_o, nxt_seen, nxt_clr, relay_ser_clk_n_o, nxt_ncl};
   end
   a_reset_gates_card: assert property (!processor_reset_o |-> !card_addr_clear_o &&
      card_addr_advance_n_o && relay_load_select_n_o) else $error("card pin moved in reset");
   a_periph_half_period: assert property (seen_ff && (periph_clk_o != prev_ff)
      |-> run_ff == 5'h0D) else $error("peripheral clock half period wrong");
   a_clear_width: assert property ($rose(card_addr_clear_o) |->
      card_addr_clear_o[*8] ##20 card_addr_clear_o ##1 !card_addr_clear_o)
      else $error("clear pulse width wrong");
   a_clear_once: assert property ($rose(card_addr_clear_o) |-> !clr_ff)
      else $error("second clear pulse");
   a_advance_after_clear: assert property ($fell(card_addr_clear_o) |->
      !card_addr_advance_n_o) else $error("no advance after clear");
   a_advance_width: assert property ($fell(card_addr_advance_n_o) |->
      ##27 !card_addr_advance_n_o ##1 card_addr_advance_n_o) else $error("advance width wrong");
   a_select_in_burst: assert property (!relay_load_select_n_o |-> relay_busy_o &&
      id_done_o && relay_ser_clk_n_o) else $error("select outside a burst");
   a_select_width: assert property ($fell(relay_load_select_n_o) |->
      ##27 !relay_load_select_n_o ##1 relay_load_select_n_o) else $error("select width wrong");
   a_eight_clocks: assert property (relay_done_o |-> ncl_ff == 4'h8 &&
      relay_ser_clk_n_o) else $error("burst clock count wrong");
   a_serclk_width: assert property ($fell(relay_ser_clk_n_o) |->
      ##13 !relay_ser_clk_n_o ##1 relay_ser_clk_n_o) else $error("serial clock width wrong");
   a_data_stable: assert property ($rose(relay_ser_clk_n_o) |->
      $stable(relay_serial_out_o)) else $error("data moved at load edge");
endmodule
bind matrix_relay_loader relay_monitor u_relay_monitor (.clk_i, .resetn_i, .processor_reset_o,
   .periph_clk_o, .relay_busy_o, .relay_done_o, .id_done_o, .card_addr_clear_o,
   .card_addr_advance_n_o, .relay_load_select_n_o, .relay_ser_clk_n_o, .relay_serial_out_o);

// File: bench/card_model.sv
// behavioural matrix card: id shifter and relay driver input
`timescale 1ns/100ps
module card_model (
   // pins from the loader
   input wire logic periph_i,
   input wire logic clear_i,
   input wire logic adv_n_i,
   input wire logic sck_n_i,
   input wire logic sdo_i,
   // card outputs
   output logic id_o,
   output logic [7:0] rx_o
);
   logic [7:0] sh;
   int idx;
   int nb;
   initial begin
      id_o = 1'b0;
      rx_o = 8'h00;
      idx = 0;
      nb = 8;
   end
   // clear rewinds to the first id byte
   always @(posedge clear_i) idx = 0;
   // end of advance loads the next byte, msb first
   always @(posedge adv_n_i) begin
      sh = 8'h96 + 8'(idx * 37);
      idx++;
      nb = 0;
      id_o = sh[7];
   end
   // shift after each fall; inverse once out, so stale data never passes
   always @(negedge periph_i) begin
      if (nb < 8) begin
         nb++;
         sh = sh << 1;
         id_o = (nb < 8) ? sh[7] : ~id_o;
      end
   end
   // drivers load on the rising serial clock edge
   always @(posedge sck_n_i) rx_o = {rx_o[6:0], sdo_i};
endmodule

// File: bench/matrix_relay_loader_tb.sv
// self-checking bench for the matrix card loader
`timescale 1ns/100ps
module matrix_relay_loader_tb;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic relay_req_i = 1'b0;
   logic [7:0] relay_byte_i = 8'h00;
   logic processor_reset_o, periph_clk_o, relay_busy_o, relay_done_o, id_valid_o, id_done_o;
   logic card_addr_clear_o, card_addr_advance_n_o, card_id_serial_in_i;
   logic relay_load_select_n_o, relay_ser_clk_n_o, relay_serial_out_o;
   logic [7:0] id_byte_o, id_index_o, rx;
   logic [31:0] rng = 32'hCDFC5FDB;
   logic [15:0] exp_id[$];
   logic [7:0] exp_rx[$];
   int fails = 0;
   int n_checks = 0;
   matrix_relay_loader #(.RESET_HOLD_CYC(50), .ID_BYTES(4)) u_matrix_relay_loader (
      .clk_i, .resetn_i, .processor_reset_o, .periph_clk_o, .relay_req_i, .relay_byte_i,
      .relay_busy_o, .relay_done_o, .id_byte_o, .id_index_o, .id_valid_o, .id_done_o,
      .card_addr_clear_o, .card_addr_advance_n_o, .card_id_serial_in_i,
      .relay_load_select_n_o, .relay_ser_clk_n_o, .relay_serial_out_o);
   card_model u_card_model (.periph_i(periph_clk_o), .clear_i(card_addr_clear_o),
      .adv_n_i(card_addr_advance_n_o), .sck_n_i(relay_ser_clk_n_o),
      .sdo_i(relay_serial_out_o), .id_o(card_id_serial_in_i), .rx_o(rx));
   // one counted comparison
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // verdict and end of run
   task automatic complete_run();
      if (fails == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   // 50 MHz system clock
   initial forever #10 clk_i = ~clk_i;
   // hang guard, several times the expected run
   initial begin
      #400000;
      fails++;
      complete_run();
   end
   // results matched against the oldest note
   always @(posedge clk_i) begin
      if (id_valid_o === 1'b1) check("id", {id_index_o, id_byte_o}, exp_id.pop_front());
      if (relay_done_o === 1'b1) check("relay", {8'h00, rx}, {8'h00, exp_rx.pop_front()});
   end
   // reset, early request, id read, back-to-back relay bytes, then a mid-run reset
   initial begin
      logic [31:0] r;
      logic [7:0] b;
      for (int k = 0; k < 4; k++) exp_id.push_back({8'(k), 8'h96 + 8'(k * 37)});
      repeat (2) @(posedge clk_i);
      #2 resetn_i = 1'b1;
      relay_req_i = 1'b1;
      relay_byte_i = 8'h5A;
      repeat (45) @(posedge clk_i);
      check("preset_early", processor_reset_o, 0);
      repeat (10) @(posedge clk_i);
      check("preset_late", processor_reset_o, 1);
      check("busy_early", relay_busy_o, 0);
      #2 relay_req_i = 1'b0;
      while (id_done_o !== 1'b1) @(posedge clk_i);
      #2 check("id_left", exp_id.size(), 0);
      b = 8'h00;
      relay_byte_i = b;
      relay_req_i = 1'b1;
      for (int i = 0; i < 6; i++) begin
         while (relay_busy_o !== 1'b1) @(posedge clk_i);
         exp_rx.push_back(b);
         #2 relay_byte_i = ~b;
         r = xs();
         b = (i == 0) ? 8'hFF : r[7:0];
         while (relay_load_select_n_o !== 1'b0) @(posedge clk_i);
         #2 relay_byte_i = b;
         relay_req_i = (i < 5);
         while (relay_busy_o !== 1'b0) @(posedge clk_i);
      end
      repeat (40) @(posedge clk_i);
      check("rx_left", exp_rx.size(), 0);
      // a second reset must replay the whole power-up sequence from the first byte
      for (int k = 0; k < 4; k++) exp_id.push_back({8'(k), 8'h96 + 8'(k * 37)});
      #2 resetn_i = 1'b0;
      repeat (2) @(posedge clk_i);
      #2 resetn_i = 1'b1;
      check("preset_mid", processor_reset_o, 0);
      check("id_done_mid", id_done_o, 0);
      while (id_done_o !== 1'b1) @(posedge clk_i);
      #2 check("id_left_mid", exp_id.size(), 0);
      complete_run();
   end
endmodule
